//--- hdl/host_link_service_responder.sv
/*
 Management-link service responder: APB register file, register-read
 command engine, productive-cycle counter, turbo threshold, request-table
 and thermal-margin reads.
 Assumes the register source, table and thermal inputs share pclk; only
 internal_error_signal is asynchronous.
*/
`timescale 1ns/1ps
`include "link_service_regs.svh"

module host_link_service_responder #(
    parameter int INTERNAL_ERROR_SIGNAL_SETTLE_CYCLES = `INTERNAL_ERROR_SIGNAL_SETTLE_CYC,
    parameter int RESP_TIMEOUT_CYCLES = `RESP_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Activity and performance state
    input wire logic retire_active,
    input wire logic [7:0] os_pstate_req,
    input wire logic [7:0] limit_pstate,
    input wire logic [3:0] energy_bias_setting,
    output logic [7:0] granted_pstate,
    output logic turbo_enable,
    output logic [3:0] turbo_bias,
    // Request table and failing core
    output logic [15:0] table_param,
    input wire logic [31:0] table_data,
    input wire logic [7:0] agent_enable,
    input wire logic [7:0] first_fail_core,
    input wire logic first_fail_valid,
    input wire logic internal_error_signal,
    // Thermal margin
    input wire logic [15:0] thermal_margin,
    // Architectural register source
    output logic src_req,
    output logic [7:0] src_thread,
    output logic [15:0] src_addr,
    input wire logic src_ack,
    input wire logic src_busy,
    input wire logic [1:0] src_status,
    input wire logic [63:0] src_data
);

    localparam int SETTLE_W = $clog2(INTERNAL_ERROR_SIGNAL_SETTLE_CYCLES + 1);
    localparam int TMO_W = $clog2(RESP_TIMEOUT_CYCLES + 1);

    if (INTERNAL_ERROR_SIGNAL_SETTLE_CYCLES < 1 || RESP_TIMEOUT_CYCLES < 2) begin : g_bad_param
        $error("Settle count must be 1 or more and timeout 2 or more");
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states: pready rises in the first access cycle.
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, rmux;
    logic hit;
    logic setup, xfer, wr, rd;

    link_service_pkg::frame_s frame_q, frame_d;
    logic [15:0] addr_q, addr_d;
    link_service_pkg::engine_state_e st_q, st_d;
    logic [7:0] cc_q, cc_d;
    logic [63:0] data_q, data_d;
    logic abort_q, abort_d;
    logic [3:0] idx_q, idx_d;
    logic [TMO_W-1:0] tmo_q, tmo_d;
    logic src_req_q, src_req_d;
    logic [7:0] src_thread_q, src_thread_d;
    logic [15:0] src_addr_q, src_addr_d;

    logic [31:0] pcc_q, pcc_d;
    logic [7:0] thr_q, thr_d;
    link_service_pkg::table_param_s tp_q, tp_d;
    logic [9:0] mask_q, mask_d;
    logic [31:0] tdata_q, tdata_d;
    logic [31:0] therm_q, therm_d;
    logic [7:0] grant_q, grant_d;
    logic turbo_q, turbo_d;
    logic [3:0] bias_q, bias_d;
    logic internal_error_signal_s1_q, internal_error_signal_s2_q, internal_error_signal_s3_q;
    logic [SETTLE_W-1:0] settle_q, settle_d;
    logic ffc_ready_q, ffc_ready_d;
    logic [71:0] resp_bytes;

    assign setup = psel & ~penable;
    assign xfer = psel & penable & pready_q;
    assign wr = xfer & pwrite;
    assign rd = xfer & ~pwrite;
    assign resp_bytes = {data_q, cc_q};

    always_comb begin
        hit = 1'b1;
        rmux = 32'h0000_0000;
        case (paddr)
            `OFS_FRAME: rmux = frame_q;
            `OFS_ADDR: rmux = {16'h0000, addr_q};
            `OFS_CTRL: rmux = {16'h0000, cc_q, 5'h00, abort_q, st_q == link_service_pkg::ST_DONE,
                               st_q == link_service_pkg::ST_ISSUE || st_q == link_service_pkg::ST_WAIT};
            `OFS_RESP_LO: rmux = data_q[31:0];
            `OFS_RESP_HI: rmux = data_q[63:32];
            `OFS_RESP_BYTE: rmux = {24'h000000, resp_bytes[{idx_q, 3'b000} +: 8]};
            `OFS_PCC: rmux = pcc_q;
            `OFS_TURBO: rmux = {24'h000000, thr_q};
            `OFS_TPARAM: rmux = {16'h0000, tp_q};
            `OFS_TDATA: rmux = tdata_q;
            `OFS_THERM: rmux = therm_q;
            `OFS_MASK: rmux = {22'h000000, mask_q};
            default: hit = 1'b0;
        endcase
        pready_d = setup;
        pslverr_d = setup & ~hit;
        prdata_d = setup ? rmux : prdata_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Register-read command engine
    // ------------------------------------------------------------------
    logic start, good, avail;

    assign start = wr && paddr == `OFS_CTRL && pwdata[`CTRL_START_BIT];
    assign good = frame_q.wlen == `WLEN_REG_READ && frame_q.rlen == `RLEN_REG_READ
                  && frame_q.cmd == `CMD_REG_READ;
    // IDs map to fixed slots: core = id[3:1], thread = id[0]; IDs 16..23
    // have no mask bit and are never available.
    assign avail = frame_q.proc_id <= `MAX_PROC_ID && frame_q.proc_id[7:4] == 4'h0
                   && mask_q[frame_q.proc_id[3:1]] && mask_q[4'h8 + frame_q.proc_id[0]];

    always_comb begin
        st_d = st_q;
        cc_d = cc_q;
        data_d = data_q;
        abort_d = abort_q;
        idx_d = idx_q;
        tmo_d = tmo_q;
        src_req_d = 1'b0;
        src_thread_d = src_thread_q;
        src_addr_d = src_addr_q;
        frame_d = frame_q;
        addr_d = addr_q;
        if (wr && paddr == `OFS_FRAME) begin
            frame_d = pwdata;
        end
        if (wr && paddr == `OFS_ADDR) begin
            addr_d = pwdata[15:0];
        end
        if (rd && paddr == `OFS_RESP_BYTE && idx_q != `LAST_BYTE_IDX
            && st_q == link_service_pkg::ST_DONE) begin
            idx_d = idx_q + 4'h1;
        end
        case (st_q)
            link_service_pkg::ST_IDLE, link_service_pkg::ST_DONE: begin
                if (start) begin
                    idx_d = 4'h0;
                    data_d = 64'h0;
                    abort_d = 1'b0;
                    cc_d = `CC_NONE;
                    src_thread_d = frame_q.proc_id;
                    src_addr_d = addr_q;
                    if (!good) begin
                        abort_d = 1'b1;
                        st_d = link_service_pkg::ST_DONE;
                    end else if (!avail) begin
                        cc_d = `CC_INVALID;
                        st_d = link_service_pkg::ST_DONE;
                    end else begin
                        st_d = link_service_pkg::ST_ISSUE;
                    end
                end
            end
            link_service_pkg::ST_ISSUE: begin
                if (src_busy) begin
                    cc_d = `CC_NO_RES;
                    st_d = link_service_pkg::ST_DONE;
                end else begin
                    src_req_d = 1'b1;
                    tmo_d = '0;
                    st_d = link_service_pkg::ST_WAIT;
                end
            end
            link_service_pkg::ST_WAIT: begin
                if (src_ack) begin
                    st_d = link_service_pkg::ST_DONE;
                    case (link_service_pkg::src_status_e'(src_status))
                        link_service_pkg::SRC_OK: begin
                            cc_d = `CC_PASS;
                            data_d = src_data;
                        end
                        link_service_pkg::SRC_UNIMPL: cc_d = `CC_INVALID;
                        link_service_pkg::SRC_LOW_POWER: cc_d = `CC_LOW_POWER;
                        default: cc_d = `CC_HW_FAIL;
                    endcase
                end else if (tmo_q == TMO_W'(RESP_TIMEOUT_CYCLES - 1)) begin
                    cc_d = `CC_TIMEOUT;
                    st_d = link_service_pkg::ST_DONE;
                end else begin
                    tmo_d = tmo_q + 1'b1;
                end
            end
            default: st_d = link_service_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= link_service_pkg::ST_IDLE;
            cc_q <= `CC_NONE;
            data_q <= 64'h0;
            abort_q <= 1'b0;
            idx_q <= 4'h0;
            tmo_q <= '0;
            src_req_q <= 1'b0;
            src_thread_q <= 8'h00;
            src_addr_q <= 16'h0000;
            frame_q <= 32'h0000_0000;
            addr_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cc_q <= cc_d;
            data_q <= data_d;
            abort_q <= abort_d;
            idx_q <= idx_d;
            tmo_q <= tmo_d;
            src_req_q <= src_req_d;
            src_thread_q <= src_thread_d;
            src_addr_q <= src_addr_d;
            frame_q <= frame_d;
            addr_q <= addr_d;
        end
    end

    assign src_req = src_req_q;
    assign src_thread = src_thread_q;
    assign src_addr = src_addr_q;

    // ------------------------------------------------------------------
    // Package services
    // ------------------------------------------------------------------
    // The threshold acts on p-state numbers alone; no thermal or clamp
    // input reaches this logic, so neither can bend the decision.
    always_comb begin
        pcc_d = retire_active ? pcc_q + 32'h0000_0001 : pcc_q;
        thr_d = (wr && paddr == `OFS_TURBO) ? pwdata[7:0] : thr_q;
        tp_d = (wr && paddr == `OFS_TPARAM) ? pwdata[15:0] : tp_q;
        mask_d = (wr && paddr == `OFS_MASK) ? pwdata[9:0] : mask_q;
        turbo_d = os_pstate_req > thr_q;
        grant_d = (os_pstate_req < limit_pstate) ? os_pstate_req : limit_pstate;
        bias_d = turbo_d ? energy_bias_setting : 4'h0;
        therm_d = {16'h0000, thermal_margin};
        if (tp_q.mode) begin
            tdata_d = {23'h000000, ffc_ready_q & first_fail_valid, first_fail_core};
        end else if (agent_enable[tp_q.agent[2:0]] && tp_q.agent[3] == 1'b0
                     && tp_q.bank <= `BANK_MAX && tp_q.entry <= `ENTRY_MAX) begin
            tdata_d = table_data;
        end else begin
            tdata_d = 32'h0000_0000;
        end
        // Restart the settle window on every fresh error edge.
        settle_d = settle_q;
        ffc_ready_d = ffc_ready_q;
        if (!internal_error_signal_s2_q) begin
            settle_d = '0;
            ffc_ready_d = 1'b0;
        end else if (!internal_error_signal_s3_q) begin
            settle_d = '0;
            ffc_ready_d = 1'b0;
        end else if (!ffc_ready_q) begin
            if (settle_q == SETTLE_W'(INTERNAL_ERROR_SIGNAL_SETTLE_CYCLES - 1)) begin
                ffc_ready_d = 1'b1;
            end else begin
                settle_d = settle_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcc_q <= 32'h0000_0000;
            thr_q <= `TURBO_RST;
            tp_q <= 16'h0000;
            mask_q <= `MASK_RST;
            turbo_q <= 1'b0;
            grant_q <= 8'h00;
            bias_q <= 4'h0;
            therm_q <= 32'h0000_0000;
            tdata_q <= 32'h0000_0000;
            settle_q <= '0;
            ffc_ready_q <= 1'b0;
            internal_error_signal_s1_q <= 1'b0;
            internal_error_signal_s2_q <= 1'b0;
            internal_error_signal_s3_q <= 1'b0;
        end else begin
            pcc_q <= pcc_d;
            thr_q <= thr_d;
            tp_q <= tp_d;
            mask_q <= mask_d;
            turbo_q <= turbo_d;
            grant_q <= grant_d;
            bias_q <= bias_d;
            therm_q <= therm_d;
            tdata_q <= tdata_d;
            settle_q <= settle_d;
            ffc_ready_q <= ffc_ready_d;
            internal_error_signal_s1_q <= internal_error_signal;
            internal_error_signal_s2_q <= internal_error_signal_s1_q;
            internal_error_signal_s3_q <= internal_error_signal_s2_q;
        end
    end

    assign granted_pstate = grant_q;
    assign turbo_enable = turbo_q;
    assign turbo_bias = bias_q;
    assign table_param = tp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_pcc_counts: assert property (retire_active |=> pcc_q == $past(pcc_q) + 32'h1)
        else $error("Productive count did not advance");
    a_turbo_above: assert property ((os_pstate_req > thr_q) |=> turbo_enable
        && turbo_bias == $past(energy_bias_setting))
        else $error("Request above threshold not turbo");
    a_grant_below: assert property ((os_pstate_req <= thr_q) |=> !turbo_enable
        && granted_pstate <= $past(os_pstate_req) && granted_pstate <= $past(limit_pstate))
        else $error("Request at threshold wrongly handled");
    a_abort_frame: assert property ((st_q != link_service_pkg::ST_ISSUE
        && st_q != link_service_pkg::ST_WAIT && start && !good)
        |=> abort_q && st_q == link_service_pkg::ST_DONE && !src_req)
        else $error("Malformed frame not aborted");
    a_thread_absent: assert property ((st_q != link_service_pkg::ST_ISSUE
        && st_q != link_service_pkg::ST_WAIT && start && good && !avail)
        |=> cc_q == `CC_INVALID ##1 !src_req)
        else $error("Absent thread not refused");
    a_timeout_code: assert property ((st_q == link_service_pkg::ST_WAIT && !src_ack
        && tmo_q == TMO_W'(RESP_TIMEOUT_CYCLES - 1)) |=> cc_q == `CC_TIMEOUT)
        else $error("Timeout code missing");
    a_pass_data: assert property ((st_q == link_service_pkg::ST_WAIT && src_ack
        && src_status == 2'b00) |=> cc_q == `CC_PASS && data_q == $past(src_data))
        else $error("Pass code or data wrong");
    a_req_pulse: assert property ($rose(src_req) |=> !src_req
        && st_q == link_service_pkg::ST_WAIT)
        else $error("Source request not a single pulse");
    a_ffc_settle: assert property ((internal_error_signal_s2_q && !internal_error_signal_s3_q) |=> !ffc_ready_q [*8])
        else $error("Failing core valid too early");
    a_agent_zero: assert property ((!tp_q.mode && !agent_enable[tp_q.agent[2:0]])
        |=> tdata_q == 32'h0)
        else $error("Disabled agent read not zero");
    a_first_byte: assert property ((st_q != link_service_pkg::ST_DONE) ##1
        (st_q == link_service_pkg::ST_DONE) |-> idx_q == 4'h0)
        else $error("Response stream not at code byte");

endmodule : host_link_service_responder

//--- hdl/link_service_regs.svh
/*
 Register offsets, field positions, codes, reset values and timing counts
 for the management-link service responder.
 Assumes a 125 MHz APB clock and byte addresses on an 8-bit paddr.
*/
`ifndef LINK_SERVICE_REGS_SVH
`define LINK_SERVICE_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_FRAME 8'h00
`define OFS_ADDR 8'h04
`define OFS_CTRL 8'h08
`define OFS_RESP_LO 8'h0C
`define OFS_RESP_HI 8'h10
`define OFS_RESP_BYTE 8'h14
`define OFS_PCC 8'h18
`define OFS_TURBO 8'h1C
`define OFS_TPARAM 8'h20
`define OFS_TDATA 8'h24
`define OFS_THERM 8'h28
`define OFS_MASK 8'h2C

// ----------------------------------------------------------------------
// Command format and completion codes
// ----------------------------------------------------------------------
`define WLEN_REG_READ 8'h05
`define RLEN_REG_READ 8'h09
`define CMD_REG_READ 8'hB1
`define CC_NONE 8'h00
`define CC_PASS 8'h40
`define CC_TIMEOUT 8'h80
`define CC_NO_RES 8'h81
`define CC_LOW_POWER 8'h82
`define CC_INVALID 8'h90
`define CC_HW_FAIL 8'h91
`define MAX_PROC_ID 8'h17
`define LAST_BYTE_IDX 4'h8

// ----------------------------------------------------------------------
// Field limits and reset values
// ----------------------------------------------------------------------
`define BANK_MAX 2'h2
`define ENTRY_MAX 5'h13
`define CTRL_START_BIT 0
`define TURBO_RST 8'hFF
`define MASK_RST 10'h3FF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define INTERNAL_ERROR_SIGNAL_SETTLE_NS 1000000
`define INTERNAL_ERROR_SIGNAL_SETTLE_CYC ((`INTERNAL_ERROR_SIGNAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_TIMEOUT_NS 10000
`define RESP_TIMEOUT_CYC (`RESP_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/link_service_pkg.sv
/*
 Types shared by the service responder: engine states, request frame,
 request-table parameter layout and register-source status.
 Assumes nothing of its surroundings.
*/
package link_service_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } engine_state_e;

    typedef enum logic [1:0] {
        SRC_OK = 2'b00,
        SRC_UNIMPL = 2'b01,
        SRC_LOW_POWER = 2'b10,
        SRC_FAIL = 2'b11
    } src_status_e;

    typedef struct packed {
        logic [7:0] proc_id;
        logic [7:0] cmd;
        logic [7:0] rlen;
        logic [7:0] wlen;
    } frame_s;

    typedef struct packed {
        logic [3:0] rsvd;
        logic mode;
        logic [3:0] agent;
        logic [4:0] entry;
        logic [1:0] bank;
    } table_param_s;

endpackage : link_service_pkg

//--- tb/arch_reg_source.sv
/*
 Model of the architectural register source behind the responder.
 Assumes one request at a time; answers after a set delay.
*/
`timescale 1ns/1ps
module arch_reg_source (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request side
    input wire logic src_req,
    input wire logic [7:0] src_thread,
    input wire logic [15:0] src_addr,
    // Scenario controls
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    input wire logic noack,
    // Answer side
    output logic src_ack,
    output logic [1:0] src_status,
    output logic [63:0] src_data
);
    logic [15:0] a_q;
    logic [7:0] t_q;
    logic [3:0] cnt_q;
    logic run_q;
    logic [63:0] junk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
            a_q <= 16'h0;
            t_q <= 8'h0;
            junk_q <= 64'h0;
            src_ack <= 1'b0;
        end else begin
            junk_q <= ~junk_q + 64'h1;
            src_ack <= 1'b0;
            if (src_req) begin
                run_q <= 1'b1;
                cnt_q <= delay;
                a_q <= src_addr;
                t_q <= src_thread;
            end else if (run_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (run_q) begin
                run_q <= 1'b0;
                src_ack <= !noack;
            end
        end
    end
    // Outside an answer src_status carries the inverted mode and src_data stays at zero
    assign src_status = src_ack ? mode : ~mode;
    assign src_data = src_ack ? {a_q, ~a_q, 8'h5A, t_q, a_q} : junk_q;
endmodule : arch_reg_source

//--- tb/test_host_link_service_responder.sv
/*
 Self-checking bench for the service responder over APB.
 Assumes short settle and timeout counts set at the instance.
*/
`timescale 1ns/1ps
`include "link_service_regs.svh"
module test_host_link_service_responder;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic retire_active = 0, first_fail_valid = 0, internal_error_signal = 0;
    logic src_busy = 0, noack = 0, pready, pslverr, turbo_enable, src_req, src_ack, e;
    logic [7:0] paddr = 0, os_pstate_req = 0, limit_pstate = 0, agent_enable = 0;
    logic [7:0] first_fail_core = 0, granted_pstate, src_thread;
    logic [3:0] energy_bias_setting = 0, turbo_bias;
    logic [1:0] mode = 0, src_status;
    logic [15:0] thermal_margin = 0, table_param, src_addr;
    logic [31:0] pwdata = 0, prdata, r, v, table_data;
    logic [63:0] src_data, d;
    logic [7:0] rq [3] = '{8'h21, 8'h20, 8'h30};
    logic [7:0] lm [3] = '{8'hFF, 8'hFF, 8'h10};
    logic [12:0] ex [3] = '{{8'h21, 1'h1, 4'h9}, {8'h20, 1'h0, 4'h0}, {8'h10, 1'h1, 4'h9}};
    int err_count = 0, comparisons = 0;
    // Table data follows the parameter combinationally, as the far side would
    assign table_data = {16'hC0DE, table_param};
    host_link_service_responder #(.INTERNAL_ERROR_SIGNAL_SETTLE_CYCLES(20), .RESP_TIMEOUT_CYCLES(16)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .retire_active, .os_pstate_req, .limit_pstate, .energy_bias_setting,
        .granted_pstate, .turbo_enable, .turbo_bias, .table_param, .table_data,
        .agent_enable, .first_fail_core, .first_fail_valid, .internal_error_signal,
        .thermal_margin, .src_req, .src_thread, .src_addr, .src_ack, .src_busy,
        .src_status, .src_data);
    arch_reg_source u_src (.pclk, .presetn, .src_req, .src_thread, .src_addr, .mode,
        .delay(4'h3), .noack, .src_ack, .src_status, .src_data);
    initial begin
        forever #4 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task end_sim;
        if (err_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            end_sim();
        end
        e = pslverr;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task tcase(input logic [31:0] m, fr, input logic [1:0] md, input logic b, na,
               input logic [8:0] ex9);
        int n;
        apb(1, `OFS_MASK, m);
        mode <= md;
        src_busy <= b;
        noack <= na;
        apb(1, `OFS_FRAME, fr);
        apb(1, `OFS_ADDR, 32'h0401);
        apb(1, `OFS_CTRL, 32'h1);
        n = 0;
        do begin
            apb(0, `OFS_CTRL, 0);
            n++;
        end while (r[1:0] !== 2'b10 && n < 40);
        if (n >= 40) begin
            err_count++;
            end_sim();
        end
        chk("cc_abort", {r[15:8], r[2]}, ex9);
    endtask : tcase
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFS_TURBO, 0);
        chk("turbo_rst", r, 32'hFF);
        apb(0, `OFS_MASK, 0);
        chk("mask_rst", r, 32'h3FF);
        apb(0, 8'h30, 0);
        chk("unmapped", {r, e}, 33'h1);
        apb(0, `OFS_PCC, 0);
        v = r;
        retire_active <= 1'b1;
        repeat (10) @(posedge pclk);
        retire_active <= 1'b0;
        apb(0, `OFS_PCC, 0);
        chk("pcc", r - v, 32'd10);
        apb(1, `OFS_TURBO, 32'h20);
        energy_bias_setting <= 4'h9;
        for (int i = 0; i < 3; i++) begin
            os_pstate_req <= rq[i];
            limit_pstate <= lm[i];
            repeat (3) @(posedge pclk);
            chk("turbo", {granted_pstate, turbo_enable, turbo_bias}, ex[i]);
        end
        thermal_margin <= 16'h8123;
        apb(0, `OFS_THERM, 0);
        chk("therm", r, 32'h8123);
        agent_enable <= 8'h04;
        apb(1, `OFS_TPARAM, 32'h014E);
        apb(0, `OFS_TDATA, 0);
        chk("param", table_param, 16'h014E);
        chk("tdata", r, 32'hC0DE014E);
        apb(1, `OFS_TPARAM, 32'h018E);
        apb(0, `OFS_TDATA, 0);
        chk("tdata_off", r, 32'h0);
        first_fail_core <= 8'h05;
        first_fail_valid <= 1'b1;
        internal_error_signal <= 1'b1;
        apb(1, `OFS_TPARAM, 32'h0FFF);
        apb(0, `OFS_TDATA, 0);
        chk("core_early", r, 32'h005);
        repeat (30) @(posedge pclk);
        apb(0, `OFS_TDATA, 0);
        chk("core", r, 32'h105);
        // Good read: one pass, then the returned bytes in link order
        tcase(32'h3FF, 32'h02B10905, 2'd0, 0, 0, {8'h40, 1'b0});
        chk("src", {src_thread, src_addr}, 24'h020401);
        d = {16'h0401, 16'hFBFE, 8'h5A, 8'h02, 16'h0401};
        apb(0, `OFS_RESP_LO, 0);
        chk("lo", r, d[31:0]);
        apb(0, `OFS_RESP_HI, 0);
        chk("hi", r, d[63:32]);
        for (int i = 0; i < 9; i++) begin
            apb(0, `OFS_RESP_BYTE, 0);
            chk("byte", r[7:0], i == 0 ? 8'h40 : d[8*(i-1)+:8]);
        end
        tcase(32'h3FF, 32'h02B10906, 2'd0, 0, 0, 9'h001);
        tcase(32'h3FF, 32'h02B10805, 2'd0, 0, 0, 9'h001);
        tcase(32'h3FF, 32'h02B20905, 2'd0, 0, 0, 9'h001);
        tcase(32'h3FF, 32'h18B10905, 2'd0, 0, 0, {8'h90, 1'b0});
        tcase(32'h3FB, 32'h04B10905, 2'd0, 0, 0, {8'h90, 1'b0});
        tcase(32'h3FB, 32'h03B10905, 2'd0, 0, 0, {8'h40, 1'b0});
        tcase(32'h1FF, 32'h03B10905, 2'd0, 0, 0, {8'h90, 1'b0});
        tcase(32'h1FF, 32'h02B10905, 2'd0, 0, 0, {8'h40, 1'b0});
        tcase(32'h3FF, 32'h02B10905, 2'd1, 0, 0, {8'h90, 1'b0});
        tcase(32'h3FF, 32'h02B10905, 2'd2, 0, 0, {8'h82, 1'b0});
        tcase(32'h3FF, 32'h02B10905, 2'd3, 0, 0, {8'h91, 1'b0});
        tcase(32'h3FF, 32'h02B10905, 2'd0, 1, 0, {8'h81, 1'b0});
        tcase(32'h3FF, 32'h02B10905, 2'd0, 0, 1, {8'h80, 1'b0});
        end_sim();
    end
endmodule : test_host_link_service_responder
